// [logic/pldio_pkg.sv]
// Types shared by the PLD I/O port block.
// Assumes pldio_regs.svh carries the numeric constants.
package pldio_pkg;

  typedef logic [7:0] pldio_byte_t;
  typedef logic [3:0][7:0] pldio_ports_t;

  // One-hot output source of a single pin
  typedef enum logic [3:0] {
    PLDIO_SRC_DATA = 4'b0001,
    PLDIO_SRC_ADDR = 4'b0010,
    PLDIO_SRC_PLD = 4'b0100,
    PLDIO_SRC_PERIPH = 4'b1000
  } pldio_src_t;

endpackage : pldio_pkg

// [logic/pldio_port_cfg.sv]
// Mode, direction and drive configuration for four programmable I/O ports, with the
// MCU-visible configuration and data registers and the per-pin output multiplexer.
// Assumes a synchronous MCU bus already decoded to the I/O register space, pins sampled on clk,
// and PLD product terms / macrocell outputs supplied by the surrounding logic array.
//
// Summary of operation
// - PLD pin driven when product term or direction
// - Address out when mode and direction, or term
// - Pins 3-0 carry a3-a0, 7-4 carry a7-a4
// - Memory config bit 7 makes port A buffer
// - Buffer tri-stated while peripheral selects are low; here port A falls back to its PLD, address or data source
// - Mode bit: 0 MCU I/O, 1 address; A,B only
// - Register bit n controls only pin n
// - All configuration registers reset to 00h
// - Direction 1 output, 0 input; default input
// - Without product term, direction alone decides, except port A buffer, driven by MCU write
// - Port D direction has only bits 2,1
// - Drive bit 1 open drain, 0 push-pull (A,B bits 7-4, all of C)
// - Drive bit 1 fast slew, 0 slow (A,B bits 3-0, D bits 2,1)
// - Config registers read/write over MCU bus
// - Port C group two pins 2,3,4,7; D chip selects; A buffer
// - Data out drives pins when enabled, reads back
// - Read-only register shows effective driver enables
`include "pldio_regs.svh"
`timescale 1ns/1ps

module pldio_port_cfg (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // MCU access to the I/O register space
  input wire logic io_sel,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata_r,
  // MCU address bus for latched address out
  input wire logic ale,
  input wire logic [7:0] mcu_addr_lo,
  // MCU data bus for the peripheral buffer
  input wire logic [7:0] mcu_data_out,
  input wire logic mcu_bus_wr,
  input wire logic mcu_bus_rd,
  output logic [7:0] periph_rdata_r,
  output logic periph_rdata_valid_r,
  // Peripheral buffer controls
  input wire logic periph_buffer_enable,
  input wire logic periph_select_0,
  input wire logic periph_select_1,
  // PLD array: output-enable product terms, macrocell outputs and their pin assignment
  input wire logic [3:0][7:0] pld_oe_term,
  input wire logic [3:0][7:0] pld_cell_out,
  input wire logic [3:0][7:0] pld_cell_use,
  // Port pins, index [port][bit], ports A..D
  input wire logic [3:0][7:0] pin_in,
  output logic [3:0][7:0] pin_out_r,
  output logic [3:0][7:0] pin_oe_r,
  output logic [3:0][7:0] pin_fast_slew_r
);

  localparam pldio_pkg::pldio_ports_t PIN_CAP = `PLDIO_PIN_CAP;
  localparam pldio_pkg::pldio_ports_t MODE_CAP = `PLDIO_MODE_CAP;
  localparam pldio_pkg::pldio_ports_t PLD_CAP = `PLDIO_PLD_CAP;
  localparam pldio_pkg::pldio_ports_t OD_CAP = `PLDIO_OD_CAP;
  localparam pldio_pkg::pldio_ports_t SLEW_CAP = `PLDIO_SLEW_CAP;

  // Configuration and data state
  pldio_pkg::pldio_ports_t mode_r;
  pldio_pkg::pldio_ports_t dir_r;
  pldio_pkg::pldio_ports_t drive_r;
  pldio_pkg::pldio_ports_t dout_r;
  pldio_pkg::pldio_byte_t addr_latch_r;

  // Per-pin next values
  pldio_pkg::pldio_ports_t out_nxt;
  pldio_pkg::pldio_ports_t oe_nxt;
  pldio_pkg::pldio_ports_t enable_nxt;

  // Register decode
  wire logic [3:0] acc_kind = io_addr[7:4];
  wire logic [1:0] acc_port = io_addr[1:0];
  wire logic acc_pad_ok = (io_addr[3:2] == `PLDIO_PAD_ZERO);
  wire logic acc_wr = io_sel & io_wr & acc_pad_ok;
  wire logic acc_rd = io_sel & io_rd & acc_pad_ok;
  wire logic wr_dout = acc_wr & (acc_kind == `PLDIO_KIND_DATA_OUT);
  wire logic wr_mode = acc_wr & (acc_kind == `PLDIO_KIND_MODE_SEL);
  wire logic wr_dir = acc_wr & (acc_kind == `PLDIO_KIND_DIRECTION);
  wire logic wr_drive = acc_wr & (acc_kind == `PLDIO_KIND_DRIVE_SEL);

  // Peripheral buffer is live only while a select term is high
  wire logic periph_active = periph_buffer_enable & (periph_select_0 | periph_select_1);

  // Address latch follows the MCU strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_latch_r <= `PLDIO_RESET_VAL;
    end else if (ale) begin
      addr_latch_r <= mcu_addr_lo;
    end
  end

  genvar p;
  genvar b;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_port
      wire logic sel_port = (acc_port == 2'(p));

      // Unimplemented bits are never stored, so they cannot steer a pin
      always_ff @(posedge clk) begin
        if (rst) begin
          mode_r[p] <= `PLDIO_RESET_VAL;
          dir_r[p] <= `PLDIO_RESET_VAL;
          drive_r[p] <= `PLDIO_RESET_VAL;
          dout_r[p] <= `PLDIO_RESET_VAL;
        end else begin
          if (wr_mode & sel_port) begin
            mode_r[p] <= io_wdata & MODE_CAP[p];
          end
          if (wr_dir & sel_port) begin
            dir_r[p] <= io_wdata & PIN_CAP[p];
          end
          if (wr_drive & sel_port) begin
            drive_r[p] <= io_wdata & (OD_CAP[p] | SLEW_CAP[p]);
          end
          if (wr_dout & sel_port) begin
            dout_r[p] <= io_wdata & PIN_CAP[p];
          end
        end
      end

      for (b = 0; b < 8; b = b + 1) begin : g_pin
        // Each term below reads only bit b of port p, except periph_ok (no pin bit) and addr_bit (bit b of the address latch)
        wire logic term = pld_oe_term[p][b] & PIN_CAP[p][b];
        wire logic dir = dir_r[p][b];
        wire logic pld_ok = pld_cell_use[p][b] & PLD_CAP[p][b];
        wire logic addr_ok = mode_r[p][b] & MODE_CAP[p][b];
        wire logic periph_ok = (p == 0) & periph_active;
        wire logic addr_bit = addr_latch_r[b];
        wire logic od_sel = drive_r[p][b] & OD_CAP[p][b];
        pldio_pkg::pldio_src_t src;
        logic drv;
        logic val;

        always_comb begin
          if (periph_ok) begin
            src = pldio_pkg::PLDIO_SRC_PERIPH;
          end else if (pld_ok) begin
            src = pldio_pkg::PLDIO_SRC_PLD;
          end else if (addr_ok) begin
            src = pldio_pkg::PLDIO_SRC_ADDR;
          end else begin
            src = pldio_pkg::PLDIO_SRC_DATA;
          end
        end

        always_comb begin
          drv = 1'b0;
          val = 1'b0;
          unique case (src)
            pldio_pkg::PLDIO_SRC_PERIPH: begin
              // Only drive toward the peripheral during an MCU write cycle
              drv = mcu_bus_wr;
              val = mcu_data_out[b];
            end
            pldio_pkg::PLDIO_SRC_PLD: begin
              drv = term | dir;
              val = pld_cell_out[p][b];
            end
            pldio_pkg::PLDIO_SRC_ADDR: begin
              drv = (addr_ok & dir) | term;
              val = addr_bit;
            end
            pldio_pkg::PLDIO_SRC_DATA: begin
              drv = dir | term;
              val = dout_r[p][b];
            end
          endcase
        end

        // Open drain releases the pin instead of driving a one
        assign enable_nxt[p][b] = drv & PIN_CAP[p][b];
        assign oe_nxt[p][b] = enable_nxt[p][b] & ~(od_sel & val);
        assign out_nxt[p][b] = val & ~od_sel;
      end
    end
  endgenerate

  // Effective enable shown to software, before the open-drain release
  pldio_pkg::pldio_ports_t enable_r;

  // Read-back selection
  pldio_pkg::pldio_byte_t rd_din;
  pldio_pkg::pldio_byte_t rd_dout;
  pldio_pkg::pldio_byte_t rd_mode;
  pldio_pkg::pldio_byte_t rd_dir;
  pldio_pkg::pldio_byte_t rd_drive;
  pldio_pkg::pldio_byte_t rd_enable;
  pldio_pkg::pldio_byte_t rd_nxt;

  assign rd_din = pin_in[acc_port] & PIN_CAP[acc_port];
  assign rd_dout = dout_r[acc_port];
  assign rd_mode = mode_r[acc_port];
  assign rd_dir = dir_r[acc_port];
  assign rd_drive = drive_r[acc_port];
  assign rd_enable = enable_r[acc_port];

  always_comb begin
    unique case (acc_kind)
      `PLDIO_KIND_DATA_IN: rd_nxt = rd_din;
      `PLDIO_KIND_DATA_OUT: rd_nxt = rd_dout;
      `PLDIO_KIND_MODE_SEL: rd_nxt = rd_mode;
      `PLDIO_KIND_DIRECTION: rd_nxt = rd_dir;
      `PLDIO_KIND_DRIVE_SEL: rd_nxt = rd_drive;
      `PLDIO_KIND_ENABLE_OUT: rd_nxt = rd_enable;
      default: rd_nxt = `PLDIO_UNMAPPED_VAL;
    endcase
  end

  // Read data holds until the next read so a slow bus can sample it late
  always_ff @(posedge clk) begin
    if (rst) begin
      io_rdata_r <= `PLDIO_RESET_VAL;
    end else if (acc_rd) begin
      io_rdata_r <= rd_nxt;
    end
  end

  // Pin drivers and slew are registered so the pads see no decode glitches
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out_r <= '0;
      pin_oe_r <= '0;
      enable_r <= '0;
      pin_fast_slew_r <= '0;
    end else begin
      pin_out_r <= out_nxt;
      pin_oe_r <= oe_nxt;
      enable_r <= enable_nxt;
      pin_fast_slew_r <= drive_r & SLEW_CAP;
    end
  end

  // Port A toward the MCU during a read cycle of the peripheral buffer
  always_ff @(posedge clk) begin
    if (rst) begin
      periph_rdata_r <= `PLDIO_RESET_VAL;
      periph_rdata_valid_r <= 1'b0;
    end else begin
      periph_rdata_valid_r <= periph_active & mcu_bus_rd;
      if (periph_active & mcu_bus_rd) begin
        periph_rdata_r <= pin_in[0];
      end
    end
  end

  // Software must leave direction clear on pins the PLD reads; a set bit here
  // would fight the external source, and the block cannot detect it.

endmodule : pldio_port_cfg

// [logic/pldio_regs.svh]
// Register offsets, reset values and per-port pin capability masks for the PLD I/O port block.
// Assumes the includer has already pulled in nothing else; definitions only.
`ifndef PLDIO_REGS_SVH
`define PLDIO_REGS_SVH

// Byte offset inside the I/O register space is {kind[3:0], 2'b00, port[1:0]}
`define PLDIO_KIND_DATA_IN 4'h0
`define PLDIO_KIND_DATA_OUT 4'h1
`define PLDIO_KIND_MODE_SEL 4'h2
`define PLDIO_KIND_DIRECTION 4'h3
`define PLDIO_KIND_DRIVE_SEL 4'h4
`define PLDIO_KIND_ENABLE_OUT 4'h5
`define PLDIO_PAD_ZERO 2'h0

`define PLDIO_RESET_VAL 8'h00
`define PLDIO_UNMAPPED_VAL 8'h00

// Port indices
`define PLDIO_PORT_A 2'h0
`define PLDIO_PORT_B 2'h1
`define PLDIO_PORT_C 2'h2
`define PLDIO_PORT_D 2'h3

// Physically present pins, ordered {D, C, B, A}
`define PLDIO_PIN_CAP {8'h06, 8'hff, 8'hff, 8'hff}
// Pins that own a mode-select bit
`define PLDIO_MODE_CAP {8'h00, 8'h00, 8'hff, 8'hff}
// Pins that may carry a PLD output (C: group two on 2,3,4,7; D: chip selects on 2,1)
`define PLDIO_PLD_CAP {8'h06, 8'h9c, 8'hff, 8'hff}
// Drive-select meaning per bit
`define PLDIO_OD_CAP {8'h00, 8'hff, 8'hf0, 8'hf0}
`define PLDIO_SLEW_CAP {8'h06, 8'h00, 8'h0f, 8'h0f}

`endif

// [verification/pldio_pin_partner.sv]
// External devices on the port pins: they see an enabled pin and may drive a released one.
// Assumes the bench gives the drive pattern; a line nobody drives flips every cycle.
`timescale 1ns/1ps
module pldio_pin_partner (
  // Clock
  input wire logic clk,
  // Pins
  input wire logic [3:0][7:0] pin_out_r,
  input wire logic [3:0][7:0] pin_oe_r,
  input wire logic [3:0][7:0] ext_drive,
  input wire logic [3:0][7:0] ext_val,
  output logic [3:0][7:0] pin_in
);
  logic [3:0][7:0] float_r = '0;
  // A floating line must never pass for a steady level
  always_ff @(posedge clk) float_r <= ~float_r;
  assign pin_in = (pin_oe_r & pin_out_r) | (~pin_oe_r & ((ext_drive & ext_val) | (~ext_drive & float_r)));
endmodule : pldio_pin_partner

// [verification/pldio_port_cfg_props.sv]
// Port-level checker for the PLD I/O port block.
// Assumes a bind to pldio_port_cfg, with pldio_regs.svh on the include path.
`include "pldio_regs.svh"
`timescale 1ns/1ps
module pldio_port_cfg_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic io_sel,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_rdata_r,
  // Peripheral buffer
  input wire logic mcu_bus_wr,
  input wire logic mcu_bus_rd,
  input wire logic periph_buffer_enable,
  input wire logic periph_select_0,
  input wire logic periph_select_1,
  input wire logic [7:0] periph_rdata_r,
  input wire logic periph_rdata_valid_r,
  // Pins
  input wire logic [3:0][7:0] pld_oe_term,
  input wire logic [3:0][7:0] pin_in,
  input wire logic [3:0][7:0] pin_oe_r,
  input wire logic [3:0][7:0] pin_fast_slew_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire per_on = periph_buffer_enable && (periph_select_0 || periph_select_1);
  wire rd_go = io_sel && io_rd;
  AST_RESET_ZERO: assert property ($fell(rst) |-> pin_oe_r == '0 && io_rdata_r == 8'h00)
    else $error("outputs not clear after reset");
  AST_D_ABSENT: assert property ((pin_oe_r[3] & 8'hf9) == 8'h00)
    else $error("absent port D pin driven");
  AST_SLEW_CAP: assert property ((pin_fast_slew_r & ~(`PLDIO_SLEW_CAP)) == '0)
    else $error("fast slew on a pin without slew control");
  AST_PERIPH_TRI: assert property (per_on && !mcu_bus_wr |=> pin_oe_r[0] == 8'h00)
    else $error("peripheral buffer drives outside a write");
  AST_PERIPH_READ: assert property (per_on && mcu_bus_rd |=> periph_rdata_valid_r && periph_rdata_r == $past(pin_in[0]))
    else $error("peripheral read lost");
  AST_TERM_D: assert property (pld_oe_term[3][2:1] == 2'b11 |=> pin_oe_r[3][2:1] == 2'b11)
    else $error("port D term does not drive");
  AST_TERM_B: assert property (pld_oe_term[1][3:0] == 4'hf |=> pin_oe_r[1][3:0] == 4'hf)
    else $error("port B term does not drive");
  AST_UNMAPPED_RD: assert property (rd_go && io_addr[7:4] > 4'h5 && io_addr[3:2] == 2'b00 |=> io_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!rd_go |=> $stable(io_rdata_r))
    else $error("read data moved without a read");
  cover property (per_on && mcu_bus_rd);
  cover property (pld_oe_term[1][3:0] == 4'hf);
  cover property (rd_go && io_addr[7:4] > 4'h5);
endmodule : pldio_port_cfg_props

// [verification/tb_pldio_port_cfg.sv]
// Self-checking bench for the PLD I/O port block: random register traffic and pin checks.
// Assumes design, checker and pin partner are compiled first.
`include "pldio_regs.svh"
`timescale 1ns/1ps
module tb_pldio_port_cfg;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic io_sel, io_wr, io_rd, ale, mcu_bus_wr, mcu_bus_rd, periph_rdata_valid_r;
  logic periph_buffer_enable, periph_select_0, periph_select_1;
  logic [7:0] io_addr, io_wdata, io_rdata_r, mcu_addr_lo, mcu_data_out, periph_rdata_r, d, v;
  logic [3:0][7:0] pld_oe_term, pld_cell_out, pld_cell_use, pin_in, pin_out_r, pin_oe_r;
  logic [3:0][7:0] pin_fast_slew_r, ext_drive, ext_val;
  int failures = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  pldio_port_cfg dut_u (.clk, .rst, .io_sel, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata_r, .ale,
    .mcu_addr_lo, .mcu_data_out, .mcu_bus_wr, .mcu_bus_rd, .periph_rdata_r, .periph_rdata_valid_r,
    .periph_buffer_enable, .periph_select_0, .periph_select_1, .pld_oe_term, .pld_cell_out,
    .pld_cell_use, .pin_in, .pin_out_r, .pin_oe_r, .pin_fast_slew_r);
  pldio_pin_partner far_u (.clk, .pin_out_r, .pin_oe_r, .ext_drive, .ext_val, .pin_in);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input int k, input int p, input logic [7:0] x);
    @(negedge clk);
    {io_sel, io_wr, io_addr, io_wdata} = {2'b11, 4'(k), 2'b00, 2'(p), x};
    @(negedge clk);
    {io_sel, io_wr} = 2'b00;
  endtask : wr
  task automatic rd(input int k, input int p);
    @(negedge clk);
    {io_sel, io_rd, io_addr} = {2'b11, 4'(k), 2'b00, 2'(p)};
    @(negedge clk);
    {io_sel, io_rd} = 2'b00;
    d = io_rdata_r;
  endtask : rd
  function automatic logic [7:0] cap(input logic [31:0] m, input int p);
    return m[p*8 +: 8];
  endfunction : cap
  task automatic close_out;
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    v = 8'($urandom(32'h00bb7d00));
    {io_sel, io_wr, io_rd, ale, mcu_bus_wr, mcu_bus_rd} = '0;
    {periph_buffer_enable, periph_select_0, periph_select_1} = '0;
    {io_addr, io_wdata, mcu_addr_lo, mcu_data_out} = '0;
    {pld_oe_term, pld_cell_out, pld_cell_use, ext_drive, ext_val} = '0;
    repeat (2) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    for (int k = 2; k < 5; k++) begin
      for (int p = 0; p < 4; p++) begin
        rd(k, p);
        chk(d, 8'h00);
        v = $urandom;
        wr(k, p, v);
        rd(k, p);
        chk(d, v & cap(k == 2 ? `PLDIO_MODE_CAP : k == 3 ? `PLDIO_PIN_CAP : `PLDIO_OD_CAP | `PLDIO_SLEW_CAP, p));
        wr(k, p, 8'h00);
      end
    end
    rd(7, 0);
    chk(d, 8'h00);
    // No pin is a PLD input yet, so any direction value is legal
    v = $urandom;
    for (int p = 0; p < 4; p++) wr(3, p, v);
    repeat (2) @(negedge clk);
    for (int p = 0; p < 4; p++) begin
      chk(pin_oe_r[p], v & cap(`PLDIO_PIN_CAP, p));
      rd(5, p);
      chk(d, v & cap(`PLDIO_PIN_CAP, p));
    end
    v = $urandom;
    {ale, mcu_addr_lo} = {1'b1, v};
    for (int p = 0; p < 2; p++) begin
      wr(2, p, 8'hff);
      wr(3, p, 8'hff);
    end
    @(negedge clk) {ale, mcu_addr_lo} = {1'b0, ~v};
    repeat (2) @(negedge clk);
    chk(pin_out_r[0], v);
    chk(pin_oe_r[1], 8'hff);
    wr(3, 1, 8'h00);
    pld_oe_term[1] = 8'h0f;
    wr(2, 0, 8'h00);
    wr(1, 0, 8'hff);
    wr(4, 0, 8'hff);
    repeat (2) @(negedge clk);
    chk(pin_oe_r[1], 8'h0f);
    chk(pin_oe_r[0], 8'h0f);
    chk(pin_out_r[0], 8'h0f);
    chk(pin_fast_slew_r[0], 8'h0f);
    v = $urandom;
    {pld_cell_use[2], pld_cell_out[2], pld_oe_term[3]} = {8'hff, v, 8'h06};
    wr(3, 2, 8'hff);
    repeat (2) @(negedge clk);
    chk(pin_out_r[2], v & 8'h9c);
    chk(pin_oe_r[3], 8'h06);
    wr(3, 2, 8'h00);
    pld_oe_term[2] = 8'h9c;
    wr(4, 0, 8'h00);
    v = $urandom;
    {periph_buffer_enable, periph_select_1, mcu_bus_wr, mcu_data_out} = {3'b111, v};
    repeat (2) @(negedge clk);
    chk(pin_oe_r[2], 8'h9c);
    chk({pin_oe_r[0], pin_out_r[0]}, {8'hff, v});
    {mcu_bus_wr, ext_drive[0], ext_val[0]} = {1'b0, 8'hff, ~v};
    @(negedge clk) mcu_bus_rd = 1'b1;
    chk(pin_oe_r[0], 8'h00);
    @(negedge clk) mcu_bus_rd = 1'b0;
    chk({periph_rdata_valid_r, periph_rdata_r}, {1'b1, ~v});
    {periph_select_1, mcu_bus_wr} = 2'b01;
    wr(3, 0, 8'h00);
    repeat (2) @(negedge clk);
    chk(pin_oe_r[0], 8'h00);
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    close_out();
  end
endmodule : tb_pldio_port_cfg
bind pldio_port_cfg pldio_port_cfg_props chk_u (.clk, .rst, .io_sel, .io_rd, .io_addr, .io_rdata_r, .mcu_bus_wr,
  .mcu_bus_rd, .periph_buffer_enable, .periph_select_0, .periph_select_1, .periph_rdata_r,
  .periph_rdata_valid_r, .pld_oe_term, .pin_in, .pin_oe_r, .pin_fast_slew_r);
